// file: common/attn_cfg.svh
// Register offsets, field positions, reset values and limits of the attention block
// ****************************************************************
// Function
// - Master summary bit sets when its source has any enabled flag; bits 2..0 reserved
// - Interrupt line goes low while any summary bit meets its master enable
// - Writes to master summary are ignored; it reads zero after reset
// - Master enable bits 7..3 gate the five summary bits; reset to zero
// - Machine-state flags reach their summary bit only through their enable bits
// - Receive halt sets on host write, reset, bad fifo tag, illegal receive state
// - Header length below four words, loaded while splitting is on, sets receive halt and illegal host op
// - Transmit halt sets on host write, reset, illegal state, memory bus error
// - Status/space halt sets on host write, reset, pointer or page fetch error
// - Write-blocked sets on compare mismatch, clears on clean conditional write, reset
// - Write-blocked enable always reads zero, so never reaches the interrupt
// - Control bus parity error sets its flag and suppresses the write
// - MAC input parity flag sets only when checking on and frame qualifies
// - Fatal flag sets on unrecoverable bus or state machine error
// - Service flags reach the service summary only through service enables
// ****************************************************************
`ifndef ATTN_CFG_SVH
`define ATTN_CFG_SVH

`define ATTN_ADDR_MASTER_SUMMARY 8'h04
`define ATTN_ADDR_MASTER_ENABLE 8'h05
`define ATTN_ADDR_STATE_FLAGS 8'h06
`define ATTN_ADDR_STATE_ENABLES 8'h07
`define ATTN_ADDR_SERVICE_ENABLES 8'h09

`define ATTN_BIT_RECEIVE 3
`define ATTN_BIT_TRANSMIT 4
`define ATTN_BIT_SERVICE 5
`define ATTN_BIT_NO_SPACE 6
`define ATTN_BIT_MACHINE 7
`define ATTN_MASTER_USED_MASK 8'hf8

`define ATTN_FLAG_RX_HALT 0
`define ATTN_FLAG_TX_HALT 1
`define ATTN_FLAG_SS_HALT 2
`define ATTN_FLAG_ILLEGAL_OP 3
`define ATTN_FLAG_WR_BLOCKED 4
`define ATTN_FLAG_CB_PARITY 5
`define ATTN_FLAG_MAC_PARITY 6
`define ATTN_FLAG_FATAL 7

`define ATTN_STATE_FLAGS_RESET 8'h07
`define ATTN_STATE_HOST_MASK 8'hef
`define ATTN_STATE_ENABLE_MASK 8'hef
`define ATTN_SERVICE_MASK 8'h0f
`define ATTN_MIN_HEADER_WORDS 8'h04

`endif

// file: common/attn_pkg.sv
// Shared types of the attention block
package attn_pkg;
    typedef logic [7:0] byte_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_MASTER_SUMMARY,
        SEL_MASTER_ENABLE,
        SEL_STATE_FLAGS,
        SEL_STATE_ENABLES,
        SEL_SERVICE_ENABLES
    } reg_sel_e;

    typedef struct packed {
        logic rx_bad_tag;
        logic rx_state_illegal;
        logic bad_header_len;
        logic tx_state_illegal;
        logic tx_bus_error;
        logic ss_bus_error;
        logic mac_parity;
        logic fatal;
        logic cb_parity;
    } hw_events_s;
endpackage

// file: common/attn_link_if.sv
// Signals passed between the attention top and its two units
interface attn_link_if;
    attn_pkg::byte_t wr_data;
    attn_pkg::byte_t cmp_data;
    logic state_wr;
    attn_pkg::hw_events_s events;
    attn_pkg::byte_t state_flags;
    attn_pkg::byte_t state_enables;
    logic [3:0] service_flags;
    logic [3:0] service_enables;
    logic receive_any;
    logic transmit_any;
    logic no_space_any;
    attn_pkg::byte_t master_enables;
    attn_pkg::byte_t summary;
    logic int_n;

    modport top (
        output wr_data, cmp_data, state_wr, events, state_enables, service_flags,
        output service_enables, receive_any, transmit_any, no_space_any, master_enables,
        input state_flags, summary, int_n
    );
    modport state_unit (
        input wr_data, cmp_data, state_wr, events,
        output state_flags
    );
    modport summary_unit (
        input state_flags, state_enables, service_flags, service_enables,
        input receive_any, transmit_any, no_space_any, master_enables,
        output summary, int_n
    );
endinterface

// file: design/state_flag_unit.sv
// Machine-state flag register with conditional host write and hardware set events
`include "attn_cfg.svh"

module state_flag_unit (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    attn_link_if.state_unit link
);
    attn_pkg::byte_t flags_reg;
    attn_pkg::byte_t flags_next;
    attn_pkg::byte_t write_mask;
    attn_pkg::byte_t hw_set;
    logic mismatch;

    // ****************************************************************
    // Next value
    // ****************************************************************
    always_comb
    begin
        hw_set = 8'h00;
        hw_set[`ATTN_FLAG_RX_HALT] = link.events.rx_bad_tag | link.events.rx_state_illegal
            | link.events.bad_header_len;
        hw_set[`ATTN_FLAG_ILLEGAL_OP] = link.events.bad_header_len;
        hw_set[`ATTN_FLAG_TX_HALT] = link.events.tx_state_illegal
            | link.events.tx_bus_error;
        hw_set[`ATTN_FLAG_SS_HALT] = link.events.ss_bus_error;
        hw_set[`ATTN_FLAG_CB_PARITY] = link.events.cb_parity;
        hw_set[`ATTN_FLAG_MAC_PARITY] = link.events.mac_parity;
        // Any bus or state error is unrecoverable, so it also raises the fatal flag
        hw_set[`ATTN_FLAG_FATAL] = link.events.fatal | link.events.tx_bus_error
            | link.events.ss_bus_error | link.events.rx_state_illegal
            | link.events.tx_state_illegal;
        // Only bits whose compare value matches the current value take the write
        write_mask = ~(link.cmp_data ^ flags_reg) & `ATTN_STATE_HOST_MASK;
        mismatch = |((link.cmp_data ^ flags_reg) & `ATTN_STATE_HOST_MASK);
        flags_next = flags_reg;
        if (link.state_wr)
        begin
            flags_next = (flags_reg & ~write_mask) | (link.wr_data & write_mask);
            flags_next[`ATTN_FLAG_WR_BLOCKED] = mismatch;
        end
        // Hardware sets win over a host clear in the same cycle
        flags_next = flags_next | hw_set;
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            flags_reg <= `ATTN_STATE_FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end

    assign link.state_flags = flags_reg;
endmodule

// file: design/master_summary_unit.sv
// Master summary register and the active-low host interrupt
`include "attn_cfg.svh"

module master_summary_unit (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    attn_link_if.summary_unit link
);
    attn_pkg::byte_t summary_reg;
    attn_pkg::byte_t summary_next;
    logic int_n_reg;
    logic int_n_next;

    always_comb
    begin
        summary_next = 8'h00;
        summary_next[`ATTN_BIT_RECEIVE] = link.receive_any;
        summary_next[`ATTN_BIT_TRANSMIT] = link.transmit_any;
        summary_next[`ATTN_BIT_SERVICE] = |(link.service_flags & link.service_enables);
        summary_next[`ATTN_BIT_NO_SPACE] = link.no_space_any;
        // Write-blocked is masked since its enable is forced to zero
        summary_next[`ATTN_BIT_MACHINE] = |(link.state_flags & link.state_enables
            & `ATTN_STATE_ENABLE_MASK);
        // Interrupt uses the same next value so it never lags the summary
        int_n_next = ~|(summary_next & link.master_enables
            & `ATTN_MASTER_USED_MASK);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            summary_reg <= 8'h00;
            int_n_reg <= 1'b1;
        end
        else
        begin
            summary_reg <= summary_next;
            int_n_reg <= int_n_next;
        end
    end

    assign link.summary = summary_reg;
    assign link.int_n = int_n_reg;
endmodule

// file: design/attention_interrupt_aggregator.sv
// Attention aggregator top: control bus registers, event capture and interrupt
`include "attn_cfg.svh"

module attention_interrupt_aggregator #(
    parameter bit PARITY_ODD = 1'b1
) (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] cb_addr_in,
    input wire logic [7:0] cb_data_in,
    input wire logic cb_parity_in,
    input wire logic cb_write_in,
    input wire logic cb_read_in,
    input wire logic [7:0] cb_compare_in,
    input wire logic parity_check_en_in,
    input wire logic rx_bad_tag_in,
    input wire logic rx_state_illegal_in,
    input wire logic header_split_en_in,
    input wire logic header_len_load_in,
    input wire logic [7:0] header_len_in,
    input wire logic tx_state_illegal_in,
    input wire logic tx_bus_error_in,
    input wire logic ss_bus_error_in,
    input wire logic mac_parity_error_in,
    input wire logic mac_frame_qualified_in,
    input wire logic fatal_error_in,
    input wire logic [3:0] service_flags_in,
    input wire logic receive_any_in,
    input wire logic transmit_any_in,
    input wire logic no_space_any_in,
    output logic [7:0] cb_rdata_out,
    output logic host_int_n_out,
    output logic receive_halt_out,
    output logic transmit_halt_out,
    output logic status_space_halt_out,
    output logic service_only_out
);
    attn_link_if link ();

    attn_pkg::byte_t master_enable_reg;
    attn_pkg::byte_t master_enable_next;
    attn_pkg::byte_t state_enable_reg;
    attn_pkg::byte_t state_enable_next;
    logic [3:0] service_enable_reg;
    logic [3:0] service_enable_next;
    attn_pkg::byte_t rdata_reg;
    attn_pkg::byte_t rdata_next;
    attn_pkg::reg_sel_e sel;
    logic parity_bad;
    logic wr_ok;
    attn_pkg::hw_events_s events;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic attn_pkg::reg_sel_e decode(input logic [7:0] addr);
        attn_pkg::reg_sel_e result;
        result = attn_pkg::SEL_NONE;
        if (addr == `ATTN_ADDR_MASTER_SUMMARY)
            result = attn_pkg::SEL_MASTER_SUMMARY;
        else if (addr == `ATTN_ADDR_MASTER_ENABLE)
            result = attn_pkg::SEL_MASTER_ENABLE;
        else if (addr == `ATTN_ADDR_STATE_FLAGS)
            result = attn_pkg::SEL_STATE_FLAGS;
        else if (addr == `ATTN_ADDR_STATE_ENABLES)
            result = attn_pkg::SEL_STATE_ENABLES;
        else if (addr == `ATTN_ADDR_SERVICE_ENABLES)
            result = attn_pkg::SEL_SERVICE_ENABLES;
        return result;
    endfunction

    // ****************************************************************
    // Write path and events
    // ****************************************************************
    always_comb
    begin
        sel = decode(cb_addr_in);
        // Parity is checked only on host writes, the only time the host drives data
        parity_bad = parity_check_en_in && cb_write_in
            && ((^{cb_data_in, cb_parity_in}) != PARITY_ODD);
        wr_ok = cb_write_in && !parity_bad;
        events = '0;
        events.rx_bad_tag = rx_bad_tag_in;
        events.rx_state_illegal = rx_state_illegal_in;
        events.bad_header_len = header_split_en_in && header_len_load_in
            && (header_len_in < `ATTN_MIN_HEADER_WORDS);
        events.tx_state_illegal = tx_state_illegal_in;
        events.tx_bus_error = tx_bus_error_in;
        events.ss_bus_error = ss_bus_error_in;
        events.mac_parity = parity_check_en_in && mac_parity_error_in
            && mac_frame_qualified_in;
        events.fatal = fatal_error_in;
        events.cb_parity = parity_bad;
    end

    // ****************************************************************
    // Enable registers
    // ****************************************************************
    always_comb
    begin
        master_enable_next = master_enable_reg;
        state_enable_next = state_enable_reg;
        service_enable_next = service_enable_reg;
        // Writes to the master summary fall through here and change nothing
        if (wr_ok)
        begin
            unique case (sel)
                attn_pkg::SEL_MASTER_ENABLE:
                    master_enable_next = cb_data_in & `ATTN_MASTER_USED_MASK;
                attn_pkg::SEL_STATE_ENABLES:
                    state_enable_next = cb_data_in & `ATTN_STATE_ENABLE_MASK;
                attn_pkg::SEL_SERVICE_ENABLES:
                    service_enable_next = cb_data_in[3:0];
                attn_pkg::SEL_MASTER_SUMMARY,
                attn_pkg::SEL_STATE_FLAGS,
                attn_pkg::SEL_NONE:
                    master_enable_next = master_enable_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            master_enable_reg <= 8'h00;
            state_enable_reg <= 8'h00;
            service_enable_reg <= 4'h0;
        end
        else
        begin
            master_enable_reg <= master_enable_next;
            state_enable_reg <= state_enable_next;
            service_enable_reg <= service_enable_next;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    always_comb
    begin
        rdata_next = rdata_reg;
        if (cb_read_in)
        begin
            unique case (sel)
                attn_pkg::SEL_MASTER_SUMMARY:
                    rdata_next = link.summary;
                attn_pkg::SEL_MASTER_ENABLE:
                    rdata_next = master_enable_reg;
                attn_pkg::SEL_STATE_FLAGS:
                    rdata_next = link.state_flags;
                attn_pkg::SEL_STATE_ENABLES:
                    rdata_next = state_enable_reg;
                attn_pkg::SEL_SERVICE_ENABLES:
                    rdata_next = {4'h0, service_enable_reg};
                attn_pkg::SEL_NONE:
                    rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // ****************************************************************
    // Unit links
    // ****************************************************************
    assign link.wr_data = cb_data_in;
    assign link.cmp_data = cb_compare_in;
    assign link.state_wr = wr_ok && (sel == attn_pkg::SEL_STATE_FLAGS);
    assign link.events = events;
    assign link.state_enables = state_enable_reg;
    assign link.service_flags = service_flags_in & 4'(`ATTN_SERVICE_MASK);
    assign link.service_enables = service_enable_reg;
    assign link.receive_any = receive_any_in;
    assign link.transmit_any = transmit_any_in;
    assign link.no_space_any = no_space_any_in;
    assign link.master_enables = master_enable_reg;

    state_flag_unit flags_unit (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .link(link)
    );

    master_summary_unit summary_unit (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .link(link)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Halt and interrupt outputs are flops inside the units; the host clears a halt
    // with a conditional write of zero to its bit in the state flags, and reset sets all three
    assign cb_rdata_out = rdata_reg;
    assign host_int_n_out = link.int_n;
    assign receive_halt_out = link.state_flags[`ATTN_FLAG_RX_HALT];
    assign transmit_halt_out = link.state_flags[`ATTN_FLAG_TX_HALT];
    assign status_space_halt_out = link.state_flags[`ATTN_FLAG_SS_HALT];
    assign service_only_out = link.state_flags[`ATTN_FLAG_SS_HALT];
endmodule

// file: test/host_bus_model.sv
// Host processor model driving the control register bus
module host_bus_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] data_out,
    output logic parity_out,
    output logic write_out,
    output logic read_out,
    output logic [7:0] cmp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        addr_out = 8'h00;
        data_out = 8'h00;
        parity_out = 1'b1;
        write_out = 1'b0;
        read_out = 1'b0;
        cmp_out = 8'h00;
    end
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Odd parity; bad flips it on purpose. Data inverted after release so nothing stale matches.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c,
        input logic bad);
        @(posedge clk_in);
        addr_out <= a;
        data_out <= d;
        cmp_out <= c;
        parity_out <= ~(^d) ^ bad;
        write_out <= 1'b1;
        @(posedge clk_in);
        write_out <= 1'b0;
        data_out <= ~d;
        cmp_out <= ~c;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        read_out <= 1'b1;
        @(posedge clk_in);
        read_out <= 1'b0;
        @(posedge clk_in);
        #1;
        d = rdata_in;
    endtask
endmodule

// file: test/attn_props.sv
// Port-level assertions of the attention aggregator
module attn_props (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] cb_addr_in,
    input wire logic cb_read_in,
    input wire logic rx_bad_tag_in,
    input wire logic rx_state_illegal_in,
    input wire logic header_split_en_in,
    input wire logic header_len_load_in,
    input wire logic [7:0] header_len_in,
    input wire logic tx_state_illegal_in,
    input wire logic tx_bus_error_in,
    input wire logic ss_bus_error_in,
    input wire logic [7:0] cb_rdata_out,
    input wire logic receive_halt_out,
    input wire logic transmit_halt_out,
    input wire logic status_space_halt_out,
    input wire logic service_only_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_bad_load;
        header_split_en_in && header_len_load_in && header_len_in < 8'h04;
    endsequence
    sequence s_read(a);
        cb_read_in && cb_addr_in == a;
    endsequence
    a_rx_halt_set: assert property (rx_bad_tag_in || rx_state_illegal_in |-> ##[1:2]
        receive_halt_out) else $error("receive halt missed");
    a_bad_header_halt: assert property (s_bad_load |-> ##[1:2] receive_halt_out)
        else $error("short header did not halt");
    a_tx_halt_set: assert property (tx_state_illegal_in || tx_bus_error_in |-> ##[1:2]
        transmit_halt_out) else $error("transmit halt missed");
    a_ss_halt_set: assert property (ss_bus_error_in |-> ##[1:2]
        (status_space_halt_out && service_only_out)) else $error("status halt missed");
    a_summary_reserved_zero: assert property (s_read(8'h04) |=> cb_rdata_out[2:0] == 3'h0)
        else $error("summary reserved bits set");
    a_enable_reserved_zero: assert property (s_read(8'h05) |=> cb_rdata_out[2:0] == 3'h0)
        else $error("enable reserved bits set");
    a_notify_bit_zero: assert property (s_read(8'h07) |=> !cb_rdata_out[4])
        else $error("write blocked enable read one");
    a_unmapped_read_zero: assert property (cb_read_in &&
        !(cb_addr_in inside {8'h04, 8'h05, 8'h06, 8'h07, 8'h09}) |=> cb_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_read_data_holds: assert property (!cb_read_in |=> $stable(cb_rdata_out))
        else $error("read data changed without read");
endmodule
bind attention_interrupt_aggregator attn_props attn_props_inst (.sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in), .cb_addr_in(cb_addr_in), .cb_read_in(cb_read_in),
    .rx_bad_tag_in(rx_bad_tag_in), .rx_state_illegal_in(rx_state_illegal_in),
    .header_split_en_in(header_split_en_in), .header_len_load_in(header_len_load_in),
    .header_len_in(header_len_in), .tx_state_illegal_in(tx_state_illegal_in),
    .tx_bus_error_in(tx_bus_error_in), .ss_bus_error_in(ss_bus_error_in),
    .cb_rdata_out(cb_rdata_out), .receive_halt_out(receive_halt_out),
    .transmit_halt_out(transmit_halt_out), .status_space_halt_out(status_space_halt_out),
    .service_only_out(service_only_out));

// file: test/testbench.sv
// Self-checking bench of the attention aggregator
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] cb_addr, cb_data, cb_cmp, cb_rdata, hlen = 8'h03, m, s;
    logic cb_par, cb_wr, cb_rd, pce = 1'b1, qual = 1'b1, split = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [3:0] svc = 4'h0, se;
    logic rx_any = 1'b0, tx_any = 1'b0, ns_any = 1'b0;
    logic int_n, rx_h, tx_h, ss_h, svc_only;
    wire logic [7:0] halts = {3'b000, int_n, svc_only, ss_h, tx_h, rx_h};
    int cycles = 0, miscompares = 0, check_count = 0;
    logic [7:0] rst_addr [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h0b};
    logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
    // Cases 7 and 10: parity off, frame not copied; case 9: legal length of four
    // Case 11: short length loaded while splitting is off
    logic [7:0] ev_exp [12] = '{8'h01, 8'h81, 8'h82, 8'h82, 8'h84, 8'h80, 8'h40, 8'h00,
        8'h09, 8'h00, 8'h00, 8'h00};
    host_bus_model host_bus_model_inst (.clk_in(sys_clk_in), .rdata_in(cb_rdata),
        .addr_out(cb_addr), .data_out(cb_data), .parity_out(cb_par), .write_out(cb_wr),
        .read_out(cb_rd), .cmp_out(cb_cmp));
    attention_interrupt_aggregator attention_interrupt_aggregator_inst (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .cb_addr_in(cb_addr),
        .cb_data_in(cb_data), .cb_parity_in(cb_par), .cb_write_in(cb_wr),
        .cb_read_in(cb_rd), .cb_compare_in(cb_cmp), .parity_check_en_in(pce),
        .rx_bad_tag_in(ev[0]), .rx_state_illegal_in(ev[1]), .header_split_en_in(split),
        .header_len_load_in(ev[7]), .header_len_in(hlen), .tx_state_illegal_in(ev[2]),
        .tx_bus_error_in(ev[3]), .ss_bus_error_in(ev[4]), .mac_parity_error_in(ev[6]),
        .mac_frame_qualified_in(qual), .fatal_error_in(ev[5]), .service_flags_in(svc),
        .receive_any_in(rx_any), .transmit_any_in(tx_any), .no_space_any_in(ns_any),
        .cb_rdata_out(cb_rdata), .host_int_n_out(int_n), .receive_halt_out(rx_h),
        .transmit_halt_out(tx_h), .status_space_halt_out(ss_h), .service_only_out(svc_only));
    always #5 sys_clk_in = ~sys_clk_in;
    // Ceiling well above the roughly 700 cycles the sequence needs
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            stop_test();
        end
    end
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] exp_sum(input logic [3:0] en);
        return {1'b0, ns_any, |(svc & en), tx_any, rx_any, 3'b000};
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        host_bus_model_inst.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic do_reset();
        @(posedge sys_clk_in);
        rstn_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(77));
        do_reset();
        chk("reset outputs", 8'h1f, halts);
        for (int i = 0; i < 6; i++)
            rd_chk(rst_addr[i], rst_val[i], "reset value");
        host_bus_model_inst.wr(8'h06, 8'h00, 8'h05, 1'b0);
        rd_chk(8'h06, 8'h12, "blocked write");
        host_bus_model_inst.wr(8'h06, 8'h00, 8'h12, 1'b0);
        rd_chk(8'h06, 8'h00, "clean write");
        chk("halts cleared", 8'h10, halts);
        host_bus_model_inst.wr(8'h07, 8'hff, 8'h00, 1'b0);
        rd_chk(8'h07, 8'hef, "state enables");
        host_bus_model_inst.wr(8'h05, 8'hff, 8'h00, 1'b0);
        rd_chk(8'h05, 8'hf8, "master enables");
        host_bus_model_inst.wr(8'h04, 8'hff, 8'h00, 1'b0);
        rd_chk(8'h04, 8'h00, "summary write");
        host_bus_model_inst.wr(8'h05, 8'h00, 8'h00, 1'b1);
        rd_chk(8'h05, 8'hf8, "parity drop");
        rd_chk(8'h06, 8'h20, "parity flag");
        host_bus_model_inst.wr(8'h06, 8'h00, 8'h20, 1'b0);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge sys_clk_in);
            pce <= (i != 7);
            qual <= (i != 10);
            split <= (i != 11);
            hlen <= (i == 9) ? 8'h04 : 8'h03;
            @(posedge sys_clk_in);
            ev <= 8'h01 << ((i < 6) ? i : ((i == 8 || i == 9 || i == 11) ? 7 : 6));
            @(posedge sys_clk_in);
            ev <= 8'h00;
            repeat (2) @(posedge sys_clk_in);
            #1;
            chk("interrupt", {7'h0, ev_exp[i] == 8'h00}, {7'h0, int_n});
            rd_chk(8'h04, (ev_exp[i] != 8'h00) ? 8'h80 : 8'h00, "summary");
            rd_chk(8'h06, ev_exp[i], "state flags");
            host_bus_model_inst.wr(8'h06, 8'h00, ev_exp[i], 1'b0);
            repeat (2) @(posedge sys_clk_in);
            #1;
            chk("release", 8'h01, {7'h0, int_n});
        end
        // Random enables against random source levels
        for (int n = 0; n < 40; n++)
        begin
            m = 8'($urandom) & 8'hf8;
            se = 4'($urandom);
            host_bus_model_inst.wr(8'h05, m, 8'h00, 1'b0);
            host_bus_model_inst.wr(8'h09, {4'h0, se}, 8'h00, 1'b0);
            @(posedge sys_clk_in);
            {svc, rx_any, tx_any, ns_any} <= 7'($urandom);
            repeat (3) @(posedge sys_clk_in);
            #1;
            s = exp_sum(se);
            rd_chk(8'h04, s, "random summary");
            chk("random interrupt", {7'h0, (s & m) == 8'h00}, {7'h0, int_n});
        end
        host_bus_model_inst.wr(8'h06, 8'h01, 8'h00, 1'b0);
        #1;
        chk("host halt", 8'h01, {7'h0, rx_h});
        do_reset();
        chk("second reset", 8'h1f, halts);
        rd_chk(8'h07, 8'h00, "enables cleared");
        stop_test();
    end
endmodule
